// ### adb_pkg.sv
package adb_pkg;

   // ------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------
   localparam int AW = 8;
   localparam int DW = 16;
   localparam int RW = 12;

   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [AW-1:0] OFS_LIMIT_FAIL_FLAGS    = 8'h23;
   localparam logic [AW-1:0] OFS_EXT_INPUT0_RESULT   = 8'h24;
   localparam logic [AW-1:0] OFS_EXT_INPUT1_RESULT   = 8'h25;
   localparam logic [AW-1:0] OFS_TEMPERATURE_RESULT  = 8'h26;
   localparam logic [AW-1:0] OFS_SELFDIAG_MUX_RESULT = 8'h27;
   localparam logic [AW-1:0] OFS_MEASURED_OFFSET     = 8'h28;
   localparam logic [AW-1:0] OFS_DAC_APPLIED_CODE    = 8'h2C;
   localparam logic [AW-1:0] OFS_RAW_RESULT          = 8'h2D;
   localparam logic [AW-1:0] OFS_BYPASS_CONTROL      = 8'h2E;

   // ------------------------------------------------------------
   // Field positions and reset values
   // ------------------------------------------------------------
   localparam int BIT_SUBSTITUTE_EN = 15;
   localparam int BIT_OVERRIDE_EN   = 14;
   localparam int BIT_GND_SAMPLE_DIS = 13;
   localparam int FLAG_LSB          = 1;
   localparam int FLAG_MSB          = 8;
   localparam logic [2:0] SD_LAST   = 3'h4;
   localparam logic [2:0] FIDX_EXT0 = 3'h0;
   localparam logic [2:0] FIDX_EXT1 = 3'h1;
   localparam logic [2:0] FIDX_TEMP = 3'h2;
   localparam logic [2:0] FIDX_SD0  = 3'h3;
   localparam logic [DW-1:0] RST_REG   = 16'h0000;
   localparam logic [RW-1:0] RST_FIELD = 12'h000;
   localparam logic [RW-1:0] RES_MAX   = 12'hFFF;

   typedef enum logic [1:0] {
      CH_EXT_INPUT0,
      CH_EXT_INPUT1,
      CH_TEMPERATURE,
      CH_SELFDIAG
   } adb_chan_t;

endpackage : adb_pkg

// ### adb_core_if.sv
interface adb_core_if;
   import adb_pkg::*;
   logic [RW-1:0] rawRes;
   logic [RW-1:0] measOfs;
   logic [RW-1:0] bypData;
   logic [RW-1:0] limLo;
   logic [RW-1:0] limHi;
   logic          ofstEn;
   logic          dataEn;
   logic [RW-1:0] result;
   logic [RW-1:0] offsetUsed;
   logic          fail;
   logic          wrEn;
   logic [1:0]    wrAddr;
   logic [RW-1:0] wrData;
   logic [1:0]    rdAddr;
   logic [RW-1:0] rdData;

   modport top  (output rawRes, measOfs, bypData, limLo, limHi, ofstEn, dataEn,
                 output wrEn, wrAddr, wrData, rdAddr,
                 input  result, offsetUsed, fail, rdData);
   modport calc (input  rawRes, measOfs, bypData, limLo, limHi, ofstEn, dataEn,
                 output result, offsetUsed, fail);
   modport mem  (input  wrEn, wrAddr, wrData, rdAddr, output rdData);
endinterface : adb_core_if

// ### adb_result_calc.sv
module adb_result_calc (
   adb_core_if.calc cif
);
   import adb_pkg::*;

   logic signed [13:0] diff;

   // ------------------------------------------------------------
   // Offset choice, correction and limit window
   // ------------------------------------------------------------
   always_comb begin
      cif.offsetUsed = cif.ofstEn ? cif.bypData : cif.measOfs;
      // Both offsets are signed; a negative offset raises the result
      diff = $signed({2'b00, cif.rawRes}) - $signed({{2{cif.offsetUsed[RW-1]}}, cif.offsetUsed});
      if (cif.dataEn) begin
         cif.result = cif.bypData;
      end else if (diff < 14'sd0) begin
         cif.result = RST_FIELD;
      end else if (diff > $signed({2'b00, RES_MAX})) begin
         cif.result = RES_MAX;
      end else begin
         cif.result = diff[RW-1:0];
      end
      cif.fail = (cif.result < cif.limLo) || (cif.result > cif.limHi);
   end

endmodule : adb_result_calc

// ### adb_result_mem.sv
module adb_result_mem (
   input wire logic core_clk,
   input wire logic reset,
   adb_core_if.mem  mif
);
   import adb_pkg::*;

   typedef struct packed {
      logic [3:0][RW-1:0] word;
      logic [RW-1:0]      rdData;
   } adb_mem_state_t;

   adb_mem_state_t st_q;
   adb_mem_state_t st_d;

   // ------------------------------------------------------------
   // Channel read-back store
   // ------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      // Read sees the old word when it hits a same-cycle write
      st_d.rdData = st_q.word[mif.rdAddr];
      if (mif.wrEn) begin
         st_d.word[mif.wrAddr] = mif.wrData;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign mif.rdData = st_q.rdData;

endmodule : adb_result_mem

// ### adb_bypass_regs.sv
module adb_bypass_regs (
   input  wire logic                      core_clk,
   input  wire logic                      reset,
   input  wire logic [adb_pkg::AW-1:0]    regAddr,
   input  wire logic                      regWrEn,
   input  wire logic [adb_pkg::DW-1:0]    regWrData,
   input  wire logic                      regRdEn,
   output      logic [adb_pkg::DW-1:0]    regRdData,
   output      logic                      regRdValid,
   input  wire logic                      convDone,
   input  wire adb_pkg::adb_chan_t        convChannel,
   input  wire logic [2:0]                selfDiagSelect,
   input  wire logic [adb_pkg::RW-1:0]    convRaw,
   input  wire logic [adb_pkg::RW-1:0]    limitLow,
   input  wire logic [adb_pkg::RW-1:0]    limitHigh,
   input  wire logic                      measOffsetValid,
   input  wire logic [adb_pkg::RW-1:0]    measOffset,
   input  wire logic [adb_pkg::DW-1:0]    dacCode,
   input  wire logic                      adcBusy,
   output      logic                      groundSampleEn,
   output      logic [adb_pkg::RW-1:0]    offsetInUse
);
   import adb_pkg::*;

   typedef struct packed {
      logic [FLAG_MSB-FLAG_LSB:0] flags;
      logic [RW-1:0]              rawRes;
      logic [RW-1:0]              measOfs;
      logic [DW-1:0]              dac;
      logic [RW-1:0]              bypData;
      logic                       dataEn;
      logic                       ofstEn;
      logic                       gndDis;
      logic                       rdPend;
      logic [AW-1:0]              rdSel;
      logic                       rdValid;
      logic [DW-1:0]              rdData;
      logic                       gndSample;
      logic [RW-1:0]              ofsUse;
   } adb_top_state_t;

   adb_top_state_t st_q;
   adb_top_state_t st_d;

   adb_core_if cif ();

   logic [2:0] fIdx;
   logic       fHit;

   // ------------------------------------------------------------
   // Correction unit and read-back store
   // ------------------------------------------------------------
   adb_result_calc uCalc (
      .cif (cif.calc)
   );

   adb_result_mem uMem (
      .core_clk (core_clk),
      .reset    (reset),
      .mif      (cif.mem)
   );

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      fIdx = FIDX_EXT0;
      fHit = 1'b0;

      cif.rawRes  = convRaw;
      cif.measOfs = st_q.measOfs;
      cif.bypData = st_q.bypData;
      cif.limLo   = limitLow;
      cif.limHi   = limitHigh;
      cif.ofstEn  = st_q.ofstEn;
      // Stored bit is already cleared when both are set; the mask also covers it
      cif.dataEn  = st_q.dataEn & ~st_q.ofstEn;
      cif.wrEn    = convDone;
      cif.wrAddr  = convChannel;
      cif.wrData  = cif.result;
      cif.rdAddr  = 2'(regAddr - OFS_EXT_INPUT0_RESULT);

      // Offset is only updated by its own measurement strobe
      if (measOffsetValid) begin
         st_d.measOfs = measOffset;
      end
      st_d.dac = dacCode;

      if (convDone) begin
         st_d.rawRes = convRaw;
         case (convChannel)
            CH_EXT_INPUT0: begin
               fIdx = FIDX_EXT0;
               fHit = 1'b1;
            end
            CH_EXT_INPUT1: begin
               fIdx = FIDX_EXT1;
               fHit = 1'b1;
            end
            CH_TEMPERATURE: begin
               fIdx = FIDX_TEMP;
               fHit = 1'b1;
            end
            CH_SELFDIAG: begin
               // Selector codes beyond the last source have no flag
               fIdx = FIDX_SD0 + selfDiagSelect;
               fHit = (selfDiagSelect <= SD_LAST);
            end
            default: begin
               fHit = 1'b0;
            end
         endcase
         if (fHit) begin
            st_d.flags[fIdx] = cif.fail;
         end
      end

      if (regWrEn && regAddr == OFS_BYPASS_CONTROL) begin
         st_d.bypData = regWrData[RW-1:0];
         st_d.gndDis  = regWrData[BIT_GND_SAMPLE_DIS];
         st_d.ofstEn  = regWrData[BIT_OVERRIDE_EN];
         // Guards against the software misuse of setting both
         st_d.dataEn  = regWrData[BIT_SUBSTITUTE_EN] & ~regWrData[BIT_OVERRIDE_EN];
      end

      st_d.gndSample = adcBusy & ~st_q.gndDis;
      st_d.ofsUse    = cif.offsetUsed;

      // Two-stage read: store output is registered, then the mux is
      st_d.rdPend  = regRdEn;
      st_d.rdSel   = regAddr;
      st_d.rdValid = st_q.rdPend;
      if (st_q.rdPend) begin
         case (st_q.rdSel)
            OFS_LIMIT_FAIL_FLAGS: begin
               st_d.rdData = {7'h00, st_q.flags, 1'b0};
            end
            OFS_EXT_INPUT0_RESULT: begin
               st_d.rdData = {4'h0, cif.rdData};
            end
            OFS_EXT_INPUT1_RESULT: begin
               st_d.rdData = {4'h0, cif.rdData};
            end
            OFS_TEMPERATURE_RESULT: begin
               st_d.rdData = {4'h0, cif.rdData};
            end
            OFS_SELFDIAG_MUX_RESULT: begin
               st_d.rdData = {4'h0, cif.rdData};
            end
            OFS_MEASURED_OFFSET: begin
               st_d.rdData = {4'h0, st_q.measOfs};
            end
            OFS_DAC_APPLIED_CODE: begin
               st_d.rdData = st_q.dac;
            end
            OFS_RAW_RESULT: begin
               st_d.rdData = {4'h0, st_q.rawRes};
            end
            OFS_BYPASS_CONTROL: begin
               st_d.rdData = {st_q.dataEn, st_q.ofstEn, st_q.gndDis, 1'b0, st_q.bypData};
            end
            default: begin
               st_d.rdData = RST_REG;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (reset) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign regRdData      = st_q.rdData;
   assign regRdValid     = st_q.rdValid;
   assign groundSampleEn = st_q.gndSample;
   assign offsetInUse    = st_q.ofsUse;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);

   sequence s_read(logic [AW-1:0] a);
      regRdEn && regAddr == a;
   endsequence

   sequence s_subConv;
      convDone && st_q.dataEn && !st_q.ofstEn && convChannel == CH_EXT_INPUT1;
   endsequence

   property p_flagsReserved;
      s_read(OFS_LIMIT_FAIL_FLAGS) |-> ##2 (regRdValid && regRdData[15:9] == 7'h00 && !regRdData[0]);
   endproperty
   a_flagsReserved: assert property (p_flagsReserved) else $error("flag word reserved bits set");

   property p_ext0Upper;
      s_read(OFS_EXT_INPUT0_RESULT) |-> ##2 (regRdValid && regRdData[15:12] == 4'h0);
   endproperty
   a_ext0Upper: assert property (p_ext0Upper) else $error("input result upper bits set");

   property p_offsetKept;
      (regWrEn && regAddr == OFS_BYPASS_CONTROL && !measOffsetValid) |=> $stable(st_q.measOfs);
   endproperty
   a_offsetKept: assert property (p_offsetKept) else $error("bypass write changed measured offset");

   property p_overrideUsed;
      st_q.ofstEn |=> offsetInUse == $past(st_q.bypData);
   endproperty
   a_overrideUsed: assert property (p_overrideUsed) else $error("override offset not applied");

   property p_signedOffset;
      (convDone && st_q.ofstEn && st_q.bypData == RES_MAX && convRaw != RES_MAX)
         |-> cif.result == convRaw + 12'h001;
   endproperty
   a_signedOffset: assert property (p_signedOffset) else $error("offset not taken as signed");

   property p_dacRead;
      s_read(OFS_DAC_APPLIED_CODE) |-> ##2 (regRdValid && regRdData == $past(dacCode, 2));
   endproperty
   a_dacRead: assert property (p_dacRead) else $error("dac code read mismatch");

   property p_rawRead;
      convDone ##1 (s_read(OFS_RAW_RESULT) && !convDone)
         |-> ##2 regRdData == {4'h0, $past(convRaw, 3)};
   endproperty
   a_rawRead: assert property (p_rawRead) else $error("raw result read mismatch");

   property p_substitute;
      (convDone && st_q.dataEn && !st_q.ofstEn) |-> cif.result == st_q.bypData;
   endproperty
   a_substitute: assert property (p_substitute) else $error("substitute data not used");

   property p_bothSet;
      (regWrEn && regAddr == OFS_BYPASS_CONTROL && regWrData[15] && regWrData[14])
         |=> (st_q.ofstEn && !st_q.dataEn);
   endproperty
   a_bothSet: assert property (p_bothSet) else $error("override did not take precedence");

   property p_substReadback;
      s_subConv ##1 (s_read(OFS_EXT_INPUT1_RESULT) && !convDone)
         |-> ##2 regRdData[11:0] == $past(st_q.bypData, 3);
   endproperty
   a_substReadback: assert property (p_substReadback) else $error("substitute not in read-back");

   property p_gndSample;
      adcBusy |=> groundSampleEn == !$past(st_q.gndDis);
   endproperty
   a_gndSample: assert property (p_gndSample) else $error("ground sampling wrong");

   property p_limitFlag;
      (convDone && convChannel == CH_EXT_INPUT1) |=> st_q.flags[FIDX_EXT1] == $past(cif.fail);
   endproperty
   a_limitFlag: assert property (p_limitFlag) else $error("limit flag not updated");

endmodule : adb_bypass_regs

// ### adb_bypass_regs_tb.sv
module adb_bypass_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import adb_pkg::*;

   // ------------------------------------------------------------
   // Stimulus and observed signals
   // ------------------------------------------------------------
   localparam int LIMIT = 3000;

   logic            core_clk        = 1'b0;
   logic            reset           = 1'b1;
   logic [AW-1:0]   regAddr         = 8'h00;
   logic            regWrEn         = 1'b0;
   logic [DW-1:0]   regWrData       = 16'h0000;
   logic            regRdEn         = 1'b0;
   logic [DW-1:0]   regRdData;
   logic            regRdValid;
   logic            convDone        = 1'b0;
   adb_chan_t       convChannel     = CH_EXT_INPUT0;
   logic [2:0]      selfDiagSelect  = 3'h0;
   logic [RW-1:0]   convRaw         = 12'h000;
   logic [RW-1:0]   limitLow        = 12'h000;
   logic [RW-1:0]   limitHigh       = 12'h000;
   logic            measOffsetValid = 1'b0;
   logic [RW-1:0]   measOffset      = 12'h000;
   logic [DW-1:0]   dacCode         = 16'h0000;
   logic            adcBusy         = 1'b0;
   logic            groundSampleEn;
   logic [RW-1:0]   offsetInUse;
   int              errors          = 0;
   int              cmp_count       = 0;
   int              cycles          = 0;
   logic [AW-1:0]   addrs [10]      = '{8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h2C, 8'h2D, 8'h2E, 8'h29};

   adb_bypass_regs adb_bypass_regs_inst (
      .core_clk        (core_clk),
      .reset           (reset),
      .regAddr         (regAddr),
      .regWrEn         (regWrEn),
      .regWrData       (regWrData),
      .regRdEn         (regRdEn),
      .regRdData       (regRdData),
      .regRdValid      (regRdValid),
      .convDone        (convDone),
      .convChannel     (convChannel),
      .selfDiagSelect  (selfDiagSelect),
      .convRaw         (convRaw),
      .limitLow        (limitLow),
      .limitHigh       (limitHigh),
      .measOffsetValid (measOffsetValid),
      .measOffset      (measOffset),
      .dacCode         (dacCode),
      .adcBusy         (adcBusy),
      .groundSampleEn  (groundSampleEn),
      .offsetInUse     (offsetInUse)
   );

   initial begin
      forever #4 core_clk = ~core_clk;
   end

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic wrap_up;
      $display("errors=%0d comparisons=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : wrap_up

   task automatic check(input logic [DW-1:0] got, input logic [DW-1:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : check

   // Read data is taken from the first valid pulse within six edges; the latency check expects two edges
   // With noWait set the request goes out at the edge the caller returned on,
   // so a read can follow a conversion pulse in the very next cycle
   task automatic rdChk(input logic [AW-1:0] a, input logic [DW-1:0] exp, input bit noWait = 1'b0);
      logic [DW-1:0] d;
      int            lat;
      d   = 'x;
      lat = 0;
      if (!noWait) @(posedge core_clk);
      regRdEn <= 1'b1;
      regAddr <= a;
      @(posedge core_clk);
      regRdEn <= 1'b0;
      for (int n = 1; n <= 6 && lat == 0; n++) begin
         if (n > 1) @(posedge core_clk);
         #1;
         if (regRdValid === 1'b1) begin
            lat = n;
            d   = regRdData;
         end
      end
      check(16'(lat), 16'h0002, "read latency");
      check(d, exp, "read data");
      @(posedge core_clk);
      #1;
      check({15'h0000, regRdValid}, 16'h0000, "valid pulse width");
   endtask : rdChk

   task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
      @(posedge core_clk);
      regWrEn   <= 1'b1;
      regAddr   <= a;
      regWrData <= d;
      @(posedge core_clk);
      regWrEn   <= 1'b0;
   endtask : wr

   task automatic conv(input adb_chan_t ch, input logic [2:0] sel, input logic [RW-1:0] raw,
                       input logic [RW-1:0] lo, input logic [RW-1:0] hi);
      @(posedge core_clk);
      convDone       <= 1'b1;
      convChannel    <= ch;
      selfDiagSelect <= sel;
      convRaw        <= raw;
      limitLow       <= lo;
      limitHigh      <= hi;
      @(posedge core_clk);
      convDone       <= 1'b0;
   endtask : conv

   task automatic settle;
      repeat (2) @(posedge core_clk);
      #1;
   endtask : settle

   // ------------------------------------------------------------
   // Timeout
   // ------------------------------------------------------------
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         errors++;
         $display("CHECK FAILED t=%0t timeout", $time);
         wrap_up();
      end
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (10) @(posedge core_clk);
      reset <= 1'b0;
      @(posedge core_clk);
      foreach (addrs[i]) rdChk(addrs[i], 16'h0000);
      wr(OFS_EXT_INPUT0_RESULT, 16'hFFFF);
      wr(OFS_LIMIT_FAIL_FLAGS, 16'hFFFF);
      rdChk(OFS_EXT_INPUT0_RESULT, 16'h0000);
      rdChk(OFS_LIMIT_FAIL_FLAGS, 16'h0000);
      @(posedge core_clk);
      dacCode         <= 16'hA5C3;
      measOffset      <= 12'h005;
      measOffsetValid <= 1'b1;
      @(posedge core_clk);
      measOffsetValid <= 1'b0;
      rdChk(OFS_DAC_APPLIED_CODE, 16'hA5C3);
      rdChk(OFS_MEASURED_OFFSET, 16'h0005);
      check({4'h0, offsetInUse}, 16'h0005, "offset in use");
      // Corrected results, one saturating at zero, and the limit window
      conv(CH_EXT_INPUT0, 3'h0, 12'h100, 12'h000, 12'hFFF);
      rdChk(OFS_RAW_RESULT, 16'h0100, 1'b1);
      rdChk(OFS_EXT_INPUT0_RESULT, 16'h00FB);
      conv(CH_EXT_INPUT1, 3'h0, 12'h003, 12'h010, 12'hFFF);
      rdChk(OFS_EXT_INPUT1_RESULT, 16'h0000);
      conv(CH_TEMPERATURE, 3'h0, 12'hFFF, 12'h000, 12'h800);
      rdChk(OFS_TEMPERATURE_RESULT, 16'h0FFA);
      for (int s = 0; s < 5; s++) conv(CH_SELFDIAG, 3'(s), 12'h200, 12'h300, 12'hFFF);
      rdChk(OFS_SELFDIAG_MUX_RESULT, 16'h01FB);
      rdChk(OFS_LIMIT_FAIL_FLAGS, 16'h01FC);
      conv(CH_EXT_INPUT1, 3'h0, 12'h100, 12'h000, 12'hFFF);
      rdChk(OFS_LIMIT_FAIL_FLAGS, 16'h01F8);
      // Offset override with a negative offset, ground sampling disabled
      @(posedge core_clk);
      adcBusy <= 1'b1;
      wr(OFS_BYPASS_CONTROL, 16'h7FFF);
      rdChk(OFS_BYPASS_CONTROL, 16'h6FFF);
      check({15'h0000, groundSampleEn}, 16'h0000, "ground sampling off");
      check({4'h0, offsetInUse}, 16'h0FFF, "override offset");
      rdChk(OFS_MEASURED_OFFSET, 16'h0005);
      conv(CH_EXT_INPUT0, 3'h0, 12'h100, 12'h000, 12'hFFF);
      rdChk(OFS_EXT_INPUT0_RESULT, 16'h0101);
      rdChk(OFS_RAW_RESULT, 16'h0100);
      wr(OFS_BYPASS_CONTROL, 16'h4FFF);
      settle();
      check({15'h0000, groundSampleEn}, 16'h0001, "ground sampling on");
      @(posedge core_clk);
      adcBusy <= 1'b0;
      settle();
      check({15'h0000, groundSampleEn}, 16'h0000, "idle converter");
      // Both enables: override wins and the substitute bit is dropped
      wr(OFS_BYPASS_CONTROL, 16'hC123);
      rdChk(OFS_BYPASS_CONTROL, 16'h4123);
      check({4'h0, offsetInUse}, 16'h0123, "override priority");
      conv(CH_EXT_INPUT0, 3'h0, 12'h200, 12'h000, 12'hFFF);
      rdChk(OFS_EXT_INPUT0_RESULT, 16'h00DD);
      // Result substitution feeds read-back and the limit check
      wr(OFS_BYPASS_CONTROL, 16'h8ABC);
      rdChk(OFS_BYPASS_CONTROL, 16'h8ABC);
      conv(CH_EXT_INPUT1, 3'h0, 12'h010, 12'h000, 12'h800);
      rdChk(OFS_EXT_INPUT1_RESULT, 16'h0ABC, 1'b1);
      rdChk(OFS_LIMIT_FAIL_FLAGS, 16'h01FC);
      rdChk(OFS_RAW_RESULT, 16'h0010);
      rdChk(OFS_MEASURED_OFFSET, 16'h0005);
      wrap_up();
   end

endmodule : adb_bypass_regs_tb
